/* File: design/sram_read_port.sv */
// Functional notes
// - read address taken at positive input clock, write address at negative.
// - address width 22, 21 or 20 bits by word-width option.
// - address ignored when that port was deselected at the last positive input clock.
// - read words launched on output clock edges, or input clocks singly.
// - read data outputs released when the read port is deselected.
// - read starts when read select is low at positive input clock.
// - pending read completes; drivers release after next positive launch edge (input clock in single mode).
// - every read returns exactly two words, one after the other.
// - inputs captured at positive input clock; all accesses start there.
// - inputs also captured at negative input clock; launches in single mode.
// - write starts on write select low at positive input clock; both data words ignored when deselected there.
// - write data words sampled on both input clock edges.
`timescale 1ns/100ps
`include "sram_port_defines.svh"
module sram_read_port
    import sram_port_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // configuration
    input  wire logic [1:0]  i_width_opt,
    input  wire logic        i_single_clk,
    // pins from controller
    input  wire logic        i_k,
    input  wire logic        i_k_n,
    input  wire logic        i_c,
    input  wire logic        i_c_n,
    input  wire logic [21:0] i_addr,
    input  wire logic        i_read_port_select_n,
    input  wire logic        i_write_port_select_n,
    input  wire logic [35:0] i_wdata,
    // memory array read side
    output logic [21:0]      o_mem_raddr,
    output logic             o_mem_rreq,
    input  wire logic [35:0] i_mem_rdata0,
    input  wire logic [35:0] i_mem_rdata1,
    // write capture toward the array
    output logic [21:0]      o_waddr,
    output logic             o_waddr_valid,
    output logic [35:0]      o_wdata,
    output logic             o_wdata_valid,
    output logic             o_wdata_second,
    // read data pins
    output logic [35:0]      o_q,
    output logic [35:0]      o_q_oe
);
    // ==========================================================
    // input synchronisers
    localparam int NS = 4;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [1:0]    warm;
    logic [21:0]   a1;
    logic [21:0]   a2;
    logic [35:0]   d1;
    logic [35:0]   d2;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            warm <= 2'h0;
            a1 <= '0;
            a2 <= '0;
            d1 <= '0;
            d2 <= '0;
        end else begin
            if (warm != 2'h3) begin
                warm <= warm + 2'h1;
            end
            s1 <= {i_k, i_k_n, i_c, i_c_n};
            s2 <= s1;
            s3 <= s2;
            a1 <= i_addr;
            a2 <= a1;
            d1 <= i_wdata;
            d2 <= d1;
        end
    end

    // rps and wps travel with a1/a2 path
    logic [1:0] ps1;
    logic [1:0] ps2;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ps1 <= 2'h3;
            ps2 <= 2'h3;
        end else begin
            ps1 <= {i_read_port_select_n, i_write_port_select_n};
            ps2 <= ps1;
        end
    end

    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    // s3 still holds its reset zero for a cycle after s2 has filled, so an
    // idle-high pin would look like a rise: hold detection off until then
    logic armed;
    assign armed   = (warm == 2'h3);
    assign k_rise  = armed && s2[3] && !s3[3];
    assign kn_rise = armed && s2[2] && !s3[2];
    assign c_rise  = armed && s2[1] && !s3[1];
    assign cn_rise = armed && s2[0] && !s3[0];

    // ==========================================================
    // address width
    function automatic logic [21:0] addr_mask(input logic [1:0] opt);
        case (opt)
            `WIDTH_OPT_X8, `WIDTH_OPT_X9: addr_mask = 22'h3FFFFF;
            `WIDTH_OPT_X18:               addr_mask = 22'h1FFFFF;
            default:                      addr_mask = 22'h0FFFFF;
        endcase
    endfunction

    logic [21:0] amask;
    assign amask = addr_mask(i_width_opt);

    // launch edges: output clocks, or input clocks in single mode
    logic launch_p;
    logic launch_n;
    assign launch_p = i_single_clk ? k_rise : c_rise;
    assign launch_n = i_single_clk ? kn_rise : cn_rise;

    // ==========================================================
    // read capture
    logic wr_pend;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mem_raddr <= '0;
            o_mem_rreq  <= 1'b0;
        end else begin
            o_mem_rreq <= 1'b0;
            if (k_rise && !ps2[1]) begin
                o_mem_raddr <= a2 & amask;
                o_mem_rreq  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // write capture
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend        <= 1'b0;
            o_waddr        <= '0;
            o_waddr_valid  <= 1'b0;
            o_wdata        <= '0;
            o_wdata_valid  <= 1'b0;
            o_wdata_second <= 1'b0;
        end else begin
            o_waddr_valid <= 1'b0;
            o_wdata_valid <= 1'b0;
            if (k_rise) begin
                wr_pend <= !ps2[0];
                if (!ps2[0]) begin
                    o_wdata        <= d2;
                    o_wdata_valid  <= 1'b1;
                    o_wdata_second <= 1'b0;
                end
            end else if (kn_rise && wr_pend) begin
                o_waddr        <= a2 & amask;
                o_waddr_valid  <= 1'b1;
                o_wdata        <= d2;
                o_wdata_valid  <= 1'b1;
                o_wdata_second <= 1'b1;
                wr_pend        <= 1'b0;
            end
        end
    end

    // ==========================================================
    // burst buffer: both words of a read are held until launched
    word_buf_if wb ();
    word_buf2 u_buf (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .bus     (wb)
    );

    logic      second_pend;
    word_t     second_word;
    // array answers in the same cycle as the request
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            second_pend <= 1'b0;
            second_word <= '0;
        end else begin
            if (o_mem_rreq) begin
                second_pend <= 1'b1;
                second_word <= i_mem_rdata1;
            end else if (second_pend && wb.in_ready) begin
                second_pend <= 1'b0;
            end
        end
    end

    // a new request while the companion waits overwrites that companion: the controller
    // paces reads at one per K period, which always leaves room
    assign wb.in_valid = o_mem_rreq || second_pend;
    assign wb.in_data  = o_mem_rreq ? i_mem_rdata0 : second_word;

    // ==========================================================
    // launch state machine
    rd_state_e state;
    logic      release_pend;

    assign wb.out_ready = (state == RD_WORD0 && launch_n) ||
                          ((state != RD_WORD0) && launch_p);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state        <= RD_IDLE;
            release_pend <= 1'b0;
            o_q          <= '0;
            o_q_oe       <= '0;
        end else begin
            case (state)
                RD_IDLE: begin
                    if (launch_p && wb.out_valid) begin
                        o_q    <= wb.out_data;
                        o_q_oe <= {36{1'b1}};
                        state  <= RD_WORD0;
                        release_pend <= 1'b0;
                    end else if (launch_p && release_pend) begin
                        o_q_oe       <= '0;
                        release_pend <= 1'b0;
                    end
                end
                RD_WORD0: begin
                    if (launch_n) begin
                        o_q   <= wb.out_data;
                        state <= RD_WORD1;
                    end
                end
                RD_WORD1: begin
                    if (launch_p) begin
                        if (wb.out_valid) begin
                            o_q   <= wb.out_data;
                            state <= RD_WORD0;
                        end else begin
                            o_q_oe <= '0;
                            state  <= RD_IDLE;
                        end
                    end
                end
                default: state <= RD_IDLE;
            endcase
        end
    end
endmodule

/* File: design/sram_port_defines.svh */
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
// word-width option codes
`define WIDTH_OPT_X8   2'h0
`define WIDTH_OPT_X9   2'h1
`define WIDTH_OPT_X18  2'h2
`define WIDTH_OPT_X36  2'h3
// address bits per option
`define ADDR_BITS_X8   22
`define ADDR_BITS_X18  21
`define ADDR_BITS_X36  20
`define ADDR_W         22
`define DATA_W         36
`define SYNC_STAGES    2
`endif

/* File: design/sram_port_pkg.sv */
`include "sram_port_defines.svh"
package sram_port_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef enum logic [1:0] {RD_IDLE, RD_WORD0, RD_WORD1} rd_state_e;
endpackage

/* File: design/word_buf_if.sv */
`timescale 1ns/100ps
interface word_buf_if;
    import sram_port_pkg::*;
    logic  in_valid;
    logic  in_ready;
    word_t in_data;
    logic  out_valid;
    logic  out_ready;
    word_t out_data;
    modport buf_side (input in_valid, in_data, out_ready,
                      output in_ready, out_valid, out_data);
    modport user_side (output in_valid, in_data, out_ready,
                       input in_ready, out_valid, out_data);
endinterface

/* File: design/word_buf2.sv */
`timescale 1ns/100ps
module word_buf2
    import sram_port_pkg::*;
(
    input  wire logic      i_clk,
    input  wire logic      i_rst_b,
    word_buf_if.buf_side   bus
);
    word_t     mem [2];
    logic      wr_ptr;
    logic      rd_ptr;
    logic [1:0] count;
    logic      push;
    logic      pop;

    assign bus.in_ready  = (count != 2'h2);
    assign bus.out_valid = (count != 2'h0);
    assign bus.out_data  = mem[rd_ptr];
    assign push = bus.in_valid && bus.in_ready;
    assign pop  = bus.out_valid && bus.out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* File: verification/sram_read_port_asserts.sv */
`timescale 1ns/100ps
// ==========================
// port timing checker
module sram_read_port_asserts (
    input wire logic        i_clk, i_rst_b, i_single_clk,
    input wire logic        i_k, i_k_n, i_c, i_c_n,
    input wire logic [1:0]  i_width_opt,
    input wire logic [21:0] o_mem_raddr, o_waddr,
    input wire logic        o_mem_rreq, o_waddr_valid,
    input wire logic        o_wdata_valid, o_wdata_second,
    input wire logic [35:0] o_q, o_q_oe
);
    // cycles since raw rise of k, k_n, launch pair
    logic [3:0]      pin;
    logic [3:0]      pin_d;
    logic [3:0][5:0] age;
    logic [21:0]     amask;
    assign pin = i_single_clk ? {i_k_n, i_k, i_k_n, i_k}
                              : {i_c_n, i_c, i_k_n, i_k};
    assign amask = (i_width_opt == 2'h3) ? 22'h0FFFFF
                 : (i_width_opt == 2'h2) ? 22'h1FFFFF : 22'h3FFFFF;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_d <= 4'hF;
            age   <= {4{6'h3F}};
        end else begin
            pin_d <= pin;
            for (int i = 0; i < 4; i++) begin
                if (pin[i] && !pin_d[i])
                    age[i] <= 6'h0;
                else if (age[i] != 6'h3F)
                    age[i] <= age[i] + 6'h1;
            end
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    rreq_k_a: assert property (o_mem_rreq |-> age[0] inside {[2:8]})
        else $error("read off k rise");
    rreq_gap_a: assert property (o_mem_rreq |=> !o_mem_rreq [*8])
        else $error("reads too close");
    raddr_w_a: assert property (o_mem_rreq |-> !(o_mem_raddr & ~amask))
        else $error("read address too wide");
    waddr_w_a: assert property (o_waddr_valid |-> !(o_waddr & ~amask))
        else $error("write address too wide");
    waddr_kn_a: assert property (
        o_waddr_valid |-> age[1] inside {[2:8]})
        else $error("write address off k_n rise");
    wdata_edge_a: assert property (
        o_wdata_valid |-> (o_wdata_second ? age[1] : age[0]) < 6'h9)
        else $error("write data off its edge");
    q_launch_a: assert property (
        $changed(o_q) && o_q_oe[0] |-> age[2] < 6'h9 || age[3] < 6'h9)
        else $error("read word off launch edge");
    oe_off_a: assert property (
        $fell(o_q_oe[0]) |-> age[2] < 6'h9 && o_q_oe == 36'h0)
        else $error("release off launch edge");
endmodule
bind sram_read_port sram_read_port_asserts i_sram_read_port_asserts (
    .i_clk, .i_rst_b, .i_single_clk, .i_k, .i_k_n, .i_c, .i_c_n,
    .i_width_opt, .o_mem_raddr, .o_waddr, .o_mem_rreq, .o_waddr_valid,
    .o_wdata_valid, .o_wdata_second, .o_q, .o_q_oe);

/* File: verification/sram_ctrl_model.sv */
`timescale 1ns/100ps
// ==========================
// controller: link clocks stand still between calls
module sram_ctrl_model
    import sram_port_pkg::*;
(
    input  wire logic i_c_run,
    output logic      o_k, o_k_n, o_c, o_c_n,
    output logic      o_read_port_select_n, o_write_port_select_n,
    output addr_t     o_addr,
    output word_t     o_wdata
);
    initial begin
        {o_k, o_k_n, o_c, o_c_n} = 4'h5;
        {o_read_port_select_n, o_write_port_select_n} = 2'h3;
        o_addr = 22'h0;
        o_wdata = 36'h0;
    end
    // unused lines carry the inverse of their last value
    task automatic period(input logic rn, input addr_t ra, input logic wn,
                          input addr_t wa, input word_t w0, input word_t w1);
        {o_read_port_select_n, o_write_port_select_n} = {rn, wn};
        o_addr = rn ? ~o_addr : ra;
        o_wdata = wn ? ~o_wdata : w0;
        #31.2 {o_k, o_k_n} = 2'h2;
        {o_c, o_c_n} = i_c_run ? 2'h2 : 2'h1;
        #31.3 {o_read_port_select_n, o_write_port_select_n} = 2'h3;
        o_addr = wn ? ~o_addr : wa;
        o_wdata = wn ? ~o_wdata : w1;
        #31.2 {o_k, o_k_n, o_c, o_c_n} = 4'h5;
        #31.3;
    endtask
endmodule

/* File: verification/quad_rate_sram_read_addr_port_tb.sv */
`timescale 1ns/100ps
module quad_rate_sram_read_addr_port_tb;
    import sram_port_pkg::*;
    typedef struct {
        logic [1:0] wid;
        logic       sc, rd_n, wr_n;
        addr_t      ra, wa, ea, ew;
    } row_s;
    // ==========================
    // option, single clock, selects, addresses, expected addresses
    row_s rows [4] = '{
        '{2'h0,1'h0,1'h0,1'h0,22'h3FFFFF,22'h2AAAAA,22'h3FFFFF,22'h2AAAAA},
        '{2'h1,1'h0,1'h0,1'h1,22'h3FFFFE,22'h0,22'h3FFFFE,22'h0},
        '{2'h2,1'h0,1'h0,1'h0,22'h3FFFFF,22'h355555,22'h1FFFFF,22'h155555},
        '{2'h3,1'h1,1'h0,1'h0,22'h3ABCDE,22'h2FFFFF,22'h0ABCDE,22'h0FFFFF}};
    logic       i_clk = 1'h0;
    logic       i_rst_b, i_single_clk, c_run, prev_oe, wsq[$];
    logic       i_k, i_k_n, i_c, i_c_n, o_mem_rreq, o_waddr_valid;
    logic       i_read_port_select_n, i_write_port_select_n;
    logic       o_wdata_valid, o_wdata_second;
    logic [1:0] i_width_opt;
    addr_t      i_addr, o_mem_raddr, o_waddr, raq[$], waq[$];
    word_t      i_wdata, o_wdata, o_q, o_q_oe, prev_q, wdq[$], qq[$];
    word_t      i_mem_rdata0, i_mem_rdata1;
    int         bad_count, samples_checked, cyc;
    sram_read_port i_sram_read_port (
        .i_clk, .i_rst_b, .i_width_opt, .i_single_clk, .i_k, .i_k_n, .i_c,
        .i_c_n, .i_addr, .i_read_port_select_n, .i_write_port_select_n,
        .i_wdata, .o_mem_raddr, .o_mem_rreq, .i_mem_rdata0, .i_mem_rdata1,
        .o_waddr, .o_waddr_valid, .o_wdata, .o_wdata_valid, .o_wdata_second,
        .o_q, .o_q_oe);
    sram_ctrl_model i_sram_ctrl_model (
        .i_c_run(c_run), .o_k(i_k), .o_k_n(i_k_n), .o_c(i_c), .o_c_n(i_c_n),
        .o_addr(i_addr), .o_read_port_select_n(i_read_port_select_n),
        .o_write_port_select_n(i_write_port_select_n), .o_wdata(i_wdata));
    // array words tag the companion with one bit above the address
    function automatic word_t wd(input addr_t a, input logic n);
        return {13'h0A5, n, a};
    endfunction
    task automatic chk(input string nm, input word_t seen, input word_t exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic idle2();
        repeat (2) i_sram_ctrl_model.period(1'h1, 22'h0, 1'h1, 22'h0,
                                            36'h0, 36'h0);
        @(negedge i_clk);
    endtask
    task automatic burst(input addr_t ea);
        chk("raddr", 36'(raq.pop_front()), 36'(ea));
        chk("word0", qq.pop_front(), wd(ea, 1'h0));
        chk("word1", qq.pop_front(), wd(ea, 1'h1));
    endtask
    initial begin
        i_clk = 1'h0;
        forever #2 i_clk = ~i_clk;
    end
    // memory answers half a cycle after the request, noise otherwise
    always @(negedge i_clk) begin
        cyc <= cyc + 1;
        i_mem_rdata0 <= wd(o_mem_raddr, 1'h0) ^ {36{o_mem_rreq !== 1'h1}};
        i_mem_rdata1 <= wd(o_mem_raddr, 1'h1) ^ {36{o_mem_rreq !== 1'h1}};
        if (o_mem_rreq === 1'h1) raq.push_back(o_mem_raddr);
        if (o_waddr_valid === 1'h1) waq.push_back(o_waddr);
        if (o_wdata_valid === 1'h1) begin
            wdq.push_back(o_wdata);
            wsq.push_back(o_wdata_second);
        end
        if (&o_q_oe === 1'h1 && (o_q !== prev_q || !prev_oe))
            qq.push_back(o_q);
        prev_q <= o_q;
        prev_oe <= (&o_q_oe === 1'h1);
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        {i_rst_b, i_single_clk, c_run} = 3'h1;
        {bad_count, samples_checked} = '0;
        i_width_opt = 2'h0;
        repeat (10) @(negedge i_clk);
        chk("oe reset", o_q_oe, 36'h0);
        i_rst_b = 1'h1;
        foreach (rows[i]) begin
            {i_width_opt, i_single_clk, c_run} = {rows[i].wid, rows[i].sc,
                                                  !rows[i].sc};
            i_sram_ctrl_model.period(rows[i].rd_n, rows[i].ra, rows[i].wr_n,
                rows[i].wa, wd(rows[i].wa, 1'h0), wd(rows[i].wa, 1'h1));
            idle2();
            chk("words", 36'(qq.size()), 36'h2);
            burst(rows[i].ea);
            chk("writes", 36'(waq.size()), 36'(!rows[i].wr_n));
            chk("wdata", 36'(wdq.size()), 36'({!rows[i].wr_n, 1'b0}));
            if (!rows[i].wr_n) begin
                chk("waddr", 36'(waq.pop_front()), 36'(rows[i].ew));
                chk("wd0", wdq.pop_front(), wd(rows[i].wa, 1'h0));
                chk("wd1", wdq.pop_front(), wd(rows[i].wa, 1'h1));
                chk("wd0 edge", 36'(wsq.pop_front()), 36'h0);
                chk("wd1 edge", 36'(wsq.pop_front()), 36'h1);
            end
            chk("oe off", o_q_oe, 36'h0);
            raq.delete();
            waq.delete();
            wdq.delete();
            wsq.delete();
            qq.delete();
        end
        // back to back reads: drivers must stay on across both bursts
        {i_width_opt, i_single_clk, c_run} = 4'hD;
        i_sram_ctrl_model.period(1'h0, 22'h0F0F0F, 1'h1, 22'h0, '0, '0);
        i_sram_ctrl_model.period(1'h0, 22'h30F0F1, 1'h1, 22'h0, '0, '0);
        idle2();
        chk("words", 36'(qq.size()), 36'h4);
        burst(22'h0F0F0F);
        burst(22'h00F0F1);
        // deselected ports ignore the bus; then reset drops a pending read
        i_sram_ctrl_model.period(1'h1, 22'h1, 1'h1, 22'h2, '0, '0);
        i_sram_ctrl_model.period(1'h0, 22'h55, 1'h1, 22'h0, '0, '0);
        i_rst_b = 1'h0;
        @(negedge i_clk);
        chk("reads", 36'(raq.size()), 36'h1);
        chk("writes", 36'(waq.size()), 36'h0);
        i_rst_b = 1'h1;
        raq.delete();
        qq.delete();
        idle2();
        chk("words", 36'(qq.size()), 36'h0);
        results();
    end
endmodule
